// File: cht_ccd_model.sv
/*
 * Behavioural model of the sensor's horizontal register: counts charge
 * shifts on the first horizontal clock and flags a pair that fails to cross.
 * Assumes registered horizontal clocks and drive enables on i_clk.
 */
`timescale 1ns/1ps

module cht_ccd_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_horiz_a,
  input wire logic i_horiz_a_inv,
  input wire logic [5:0] i_drive_oe_n,
  output logic [15:0] o_shift_count,
  output logic o_overlap
);
  logic prev_ff;

  // ----------------------------------------
  // Shift counting and crossover watch
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_ff <= 1'b0;
      o_shift_count <= 16'h0000;
      o_overlap <= 1'b0;
    end else begin
      prev_ff <= i_horiz_a;
      // Only a driven gate moves charge
      if (i_horiz_a && !prev_ff && !i_drive_oe_n[1]) begin
        o_shift_count <= o_shift_count + 16'h0001;
      end
      if (!i_drive_oe_n[1] && !i_drive_oe_n[2] && (i_horiz_a === i_horiz_a_inv)) begin
        o_overlap <= 1'b1;
      end
    end
  end
endmodule : cht_ccd_model

// File: cht_defs.svh
/*
 * Constants of the CCD high speed clock timing block: register map,
 * field widths, reset values and grid sizes.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CHT_DEFS_SVH
`define CHT_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CHT_ADDR_DIV 8'h30
`define CHT_ADDR_RG 8'h31
`define CHT_ADDR_HA 8'h32
`define CHT_ADDR_HB 8'h33
`define CHT_ADDR_HL 8'h34
`define CHT_ADDR_SMP 8'h35
`define CHT_ADDR_DRV 8'h36
`define CHT_ADDR_MODE 8'h37
`define CHT_ADDR_HLEN 8'h3A
`define CHT_ADDR_VLEN 8'h3B

// ----------------------------------------
// Serial frame and fields
// ----------------------------------------
`define CHT_FRAME_BITS 6'h20
`define CHT_EDGE_W 13
`define CHT_DRV_W 18
`define CHT_PIX_W 13
`define CHT_LINE_W 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CHT_EDGE_RST 13'h0800
`define CHT_RG_RST 13'h0400
`define CHT_SMP_RST 12'h0800
`define CHT_DRV_RST 18'h24924
`define CHT_HLEN_RST 13'h1FFF
`define CHT_VLEN_RST 12'hFFF

// ----------------------------------------
// Edge grid
// ----------------------------------------
`define CHT_LAST_STEP 6'h2F
`define CHT_QUAD_STEPS 6'h0C
`define CHT_OFS_MAX 4'hB

`endif

// File: cht_edge_chan.sv
/*
 * One high speed clock channel: decodes the six bit edge settings onto
 * the 48 step grid and registers a glitch free waveform and its inverse.
 * Assumes a phase input that counts 0 to 47 on the same clock.
 */
`timescale 1ns/1ps
`include "cht_defs.svh"

module cht_edge_chan (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_phase,
  input wire cht_pkg::cht_edge_t i_cfg,
  input wire logic i_pulse,
  output logic o_wave,
  output logic o_wave_n
);
  import cht_pkg::*;

  logic [5:0] rise_pos;
  logic [5:0] fall_pos;
  logic win;
  logic nxt_wave_ff;
  logic wave_ff;
  logic wave_n_ff;

  // Quadrant in top bits, offset clamped to 11
  function automatic logic [5:0] decode(input logic [5:0] v);
    logic [3:0] ofs;
    ofs = (v[3:0] > `CHT_OFS_MAX) ? `CHT_OFS_MAX : v[3:0];
    return ({4'h0, v[5:4]} * `CHT_QUAD_STEPS) + {2'h0, ofs};
  endfunction : decode

  always_comb begin
    rise_pos = decode(i_cfg.rise);
    fall_pos = decode(i_cfg.fall);
    if (i_pulse) begin
      win = (i_phase == rise_pos);
    end else if (rise_pos <= fall_pos) begin
      win = (i_phase >= rise_pos) && (i_phase < fall_pos);
    end else begin
      win = (i_phase >= rise_pos) || (i_phase < fall_pos);
    end
    nxt_wave_ff = win ^ i_cfg.pol;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wave_ff <= 1'b0;
      wave_n_ff <= 1'b1;
    end else begin
      wave_ff <= nxt_wave_ff;
      wave_n_ff <= !nxt_wave_ff;
    end
  end

  assign o_wave = wave_ff;
  assign o_wave_n = wave_n_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_inverse;
    o_wave_n == !o_wave;
  endproperty
  a_inverse: assert property (p_inverse) else $error("inverse output mismatch");

  property p_grid;
    (rise_pos <= `CHT_LAST_STEP) && (fall_pos <= `CHT_LAST_STEP);
  endproperty
  a_grid: assert property (p_grid) else $error("edge outside grid");

  property p_rise;
    (!i_pulse && i_phase == rise_pos && rise_pos != fall_pos) |=> (o_wave == !$past(i_cfg.pol));
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not placed");

  property p_fall;
    (!i_pulse && i_phase == fall_pos && rise_pos != fall_pos) |=> (o_wave == $past(i_cfg.pol));
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge not placed");

  property p_pulse;
    (i_pulse && !i_cfg.pol && i_phase != rise_pos) |=> !o_wave;
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse off location");

endmodule : cht_edge_chan

// File: cht_pkg.sv
/*
 * Types shared by the CCD high speed clock timing block.
 * Assumes cht_defs.svh is on the include path.
 */
`include "cht_defs.svh"

package cht_pkg;

  // Edge setting: polarity, falling and rising position
  typedef struct packed {
    logic pol;
    logic [5:0] fall;
    logic [5:0] rise;
  } cht_edge_t;

  // Drive setting per output, zero is high impedance
  typedef struct packed {
    logic [2:0] hl;
    logic [2:0] hb_inv;
    logic [2:0] hb;
    logic [2:0] ha_inv;
    logic [2:0] ha;
    logic [2:0] rg;
  } cht_drive_t;

  // Three wire serial configuration pins
  typedef struct packed {
    logic load_n;
    logic sck;
    logic sdata;
  } cht_ser_t;

  // All asynchronous pins, synchronised together
  typedef struct packed {
    logic mclk;
    logic ext_sync_n;
    logic vd_n;
    logic hd_n;
    cht_ser_t ser;
  } cht_pins_t;

endpackage : cht_pkg

// File: cht_timing.sv
/*
 * CCD high speed clock timing generator: serial configuration, 48 step
 * edge grid, reset gate, horizontal and sample clocks, drive enables,
 * pixel and line counters and sync in master or slave mode.
 * Assumes every pin input is asynchronous to i_clk and that each
 * two-way sync pin is resolved outside from its output enable.
 */
`timescale 1ns/1ps
`include "cht_defs.svh"

module cht_timing (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_master_clock_in,
  output logic o_inverted_clock_out,
  input wire cht_pkg::cht_ser_t i_ser,
  input wire logic i_ext_sync_n,
  input wire logic i_vertical_sync_n,
  output logic o_vertical_sync_n,
  output logic o_vertical_sync_oe_n,
  input wire logic i_horizontal_sync_n,
  output logic o_horizontal_sync_n,
  output logic o_horizontal_sync_oe_n,
  output logic o_reset_gate_clock,
  output logic o_horiz_clock_a,
  output logic o_horiz_clock_a_inv,
  output logic o_horiz_clock_b,
  output logic o_horiz_clock_b_inv,
  output logic o_last_horiz_clock,
  output logic o_reference_sample_clock,
  output logic o_data_sample_clock,
  output cht_pkg::cht_drive_t o_drive,
  output logic [5:0] o_drive_oe_n,
  output logic [12:0] o_pixel_count,
  output logic [11:0] o_line_count
);
  import cht_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  cht_pins_t pins_raw;
  cht_pins_t pins_s1_ff;
  cht_pins_t pins_s2_ff;
  cht_pins_t pins_s3_ff;

  assign pins_raw = {i_master_clock_in, i_ext_sync_n, i_vertical_sync_n, i_horizontal_sync_n, i_ser};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_s1_ff <= '1;
      pins_s2_ff <= '1;
      pins_s3_ff <= '1;
    end else begin
      pins_s1_ff <= pins_raw;
      pins_s2_ff <= pins_s1_ff;
      pins_s3_ff <= pins_s2_ff;
    end
  end

  logic sck_rise;
  logic load_rise;
  logic ext_fall;
  logic vd_fall;
  logic hd_fall;

  assign sck_rise = pins_s2_ff.ser.sck && !pins_s3_ff.ser.sck;
  assign load_rise = pins_s2_ff.ser.load_n && !pins_s3_ff.ser.load_n;
  assign ext_fall = !pins_s2_ff.ext_sync_n && pins_s3_ff.ext_sync_n;
  assign vd_fall = !pins_s2_ff.vd_n && pins_s3_ff.vd_n;
  assign hd_fall = !pins_s2_ff.hd_n && pins_s3_ff.hd_n;

  // ----------------------------------------
  // Serial port and configuration registers
  // ----------------------------------------
  logic [31:0] shift_ff, nxt_shift_ff;
  logic [5:0] bits_ff, nxt_bits_ff;
  logic div_ff, nxt_div_ff;
  logic master_ff, nxt_master_ff;
  cht_edge_t edge_ff [4];
  cht_edge_t nxt_edge_ff [4];
  logic [11:0] smp_ff, nxt_smp_ff;
  cht_drive_t drv_ff, nxt_drv_ff;
  logic [12:0] hlen_ff, nxt_hlen_ff;
  logic [11:0] vlen_ff, nxt_vlen_ff;
  logic [7:0] wr_addr;
  logic [23:0] wr_data;

  assign wr_addr = shift_ff[7:0];
  assign wr_data = shift_ff[31:8];

  always_comb begin
    nxt_shift_ff = shift_ff;
    nxt_bits_ff = bits_ff;
    nxt_div_ff = div_ff;
    nxt_master_ff = master_ff;
    nxt_edge_ff = edge_ff;
    nxt_smp_ff = smp_ff;
    nxt_drv_ff = drv_ff;
    nxt_hlen_ff = hlen_ff;
    nxt_vlen_ff = vlen_ff;
    // Address then data, least significant bit first
    if (!pins_s2_ff.ser.load_n && sck_rise && bits_ff != `CHT_FRAME_BITS) begin
      nxt_shift_ff = {pins_s2_ff.ser.sdata, shift_ff[31:1]};
      nxt_bits_ff = bits_ff + 6'h01;
    end
    if (load_rise) begin
      nxt_bits_ff = 6'h00;
      if (bits_ff == `CHT_FRAME_BITS) begin
        unique case (wr_addr)
          `CHT_ADDR_DIV: nxt_div_ff = wr_data[0];
          `CHT_ADDR_RG: nxt_edge_ff[0] = wr_data[`CHT_EDGE_W-1:0];
          `CHT_ADDR_HA: nxt_edge_ff[1] = wr_data[`CHT_EDGE_W-1:0];
          `CHT_ADDR_HB: nxt_edge_ff[2] = wr_data[`CHT_EDGE_W-1:0];
          `CHT_ADDR_HL: nxt_edge_ff[3] = wr_data[`CHT_EDGE_W-1:0];
          `CHT_ADDR_SMP: nxt_smp_ff = wr_data[11:0];
          `CHT_ADDR_DRV: nxt_drv_ff = wr_data[`CHT_DRV_W-1:0];
          `CHT_ADDR_MODE: nxt_master_ff = wr_data[0];
          `CHT_ADDR_HLEN: nxt_hlen_ff = wr_data[`CHT_PIX_W-1:0];
          `CHT_ADDR_VLEN: nxt_vlen_ff = wr_data[`CHT_LINE_W-1:0];
          default: nxt_bits_ff = 6'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_ff <= 32'h0;
      bits_ff <= 6'h00;
      div_ff <= 1'b0;
      master_ff <= 1'b1;
      edge_ff[0] <= `CHT_RG_RST;
      edge_ff[1] <= `CHT_EDGE_RST;
      edge_ff[2] <= `CHT_EDGE_RST;
      edge_ff[3] <= `CHT_EDGE_RST;
      smp_ff <= `CHT_SMP_RST;
      drv_ff <= `CHT_DRV_RST;
      hlen_ff <= `CHT_HLEN_RST;
      vlen_ff <= `CHT_VLEN_RST;
    end else begin
      shift_ff <= nxt_shift_ff;
      bits_ff <= nxt_bits_ff;
      div_ff <= nxt_div_ff;
      master_ff <= nxt_master_ff;
      edge_ff <= nxt_edge_ff;
      smp_ff <= nxt_smp_ff;
      drv_ff <= nxt_drv_ff;
      hlen_ff <= nxt_hlen_ff;
      vlen_ff <= nxt_vlen_ff;
    end
  end

  // ----------------------------------------
  // Edge grid, counters and sync outputs
  // ----------------------------------------
  logic half_ff, nxt_half_ff;
  logic [5:0] phase_ff, nxt_phase_ff;
  logic [12:0] pix_ff, nxt_pix_ff;
  logic [11:0] line_ff, nxt_line_ff;
  logic inv_clk_ff, nxt_inv_clk_ff;
  logic hd_out_ff, nxt_hd_out_ff;
  logic vd_out_ff, nxt_vd_out_ff;
  logic [5:0] oe_n_ff, nxt_oe_n_ff;
  logic step;
  logic pix_tick;
  logic restart;

  assign step = !div_ff || half_ff;
  assign pix_tick = step && (phase_ff == `CHT_LAST_STEP);
  assign restart = master_ff && ext_fall;

  always_comb begin
    nxt_half_ff = div_ff ? !half_ff : 1'b0;
    nxt_phase_ff = phase_ff;
    nxt_pix_ff = pix_ff;
    nxt_line_ff = line_ff;
    if (step) begin
      nxt_phase_ff = pix_tick ? 6'h00 : phase_ff + 6'h01;
    end
    if (pix_tick) begin
      if (pix_ff == hlen_ff) begin
        nxt_pix_ff = 13'h0000;
        nxt_line_ff = (line_ff == vlen_ff) ? 12'h000 : line_ff + 12'h001;
      end else begin
        nxt_pix_ff = pix_ff + 13'h0001;
      end
    end
    if (restart) begin
      nxt_pix_ff = 13'h0000;
      nxt_line_ff = 12'h000;
    end
    if (!master_ff && hd_fall) begin
      nxt_pix_ff = 13'h0000;
      if (vd_fall) begin
        nxt_line_ff = 12'h000;
      end
    end else if (!master_ff && vd_fall) begin
      nxt_pix_ff = 13'h0000;
      nxt_line_ff = 12'h000;
    end
    nxt_inv_clk_ff = !pins_s2_ff.mclk;
    nxt_hd_out_ff = (nxt_pix_ff != 13'h0000);
    nxt_vd_out_ff = (nxt_line_ff != 12'h000);
    nxt_oe_n_ff = {drv_ff.hl == 3'h0, drv_ff.hb_inv == 3'h0, drv_ff.hb == 3'h0,
                   drv_ff.ha_inv == 3'h0, drv_ff.ha == 3'h0, drv_ff.rg == 3'h0};
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      half_ff <= 1'b0;
      phase_ff <= 6'h00;
      pix_ff <= 13'h0000;
      line_ff <= 12'h000;
      inv_clk_ff <= 1'b0;
      hd_out_ff <= 1'b1;
      vd_out_ff <= 1'b1;
      oe_n_ff <= 6'h3F;
    end else begin
      half_ff <= nxt_half_ff;
      phase_ff <= nxt_phase_ff;
      pix_ff <= nxt_pix_ff;
      line_ff <= nxt_line_ff;
      inv_clk_ff <= nxt_inv_clk_ff;
      hd_out_ff <= nxt_hd_out_ff;
      vd_out_ff <= nxt_vd_out_ff;
      oe_n_ff <= nxt_oe_n_ff;
    end
  end

  // ----------------------------------------
  // High speed channels
  // ----------------------------------------
  cht_edge_t chan_cfg [6];
  logic [5:0] chan_pulse;
  logic [5:0] chan_wave;
  logic [5:0] chan_wave_n;

  assign chan_cfg[0] = edge_ff[0];
  assign chan_cfg[1] = edge_ff[1];
  assign chan_cfg[2] = edge_ff[2];
  assign chan_cfg[3] = edge_ff[3];
  assign chan_cfg[4] = {7'h00, smp_ff[5:0]};
  assign chan_cfg[5] = {7'h00, smp_ff[11:6]};
  assign chan_pulse = 6'h30;

  // Mode does not enter the channels
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chan
      cht_edge_chan u_chan (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_phase(phase_ff),
        .i_cfg(chan_cfg[gi]),
        .i_pulse(chan_pulse[gi]),
        .o_wave(chan_wave[gi]),
        .o_wave_n(chan_wave_n[gi])
      );
    end
  endgenerate

  assign o_reset_gate_clock = chan_wave[0];
  assign o_horiz_clock_a = chan_wave[1];
  assign o_horiz_clock_a_inv = chan_wave_n[1];
  assign o_horiz_clock_b = chan_wave[2];
  assign o_horiz_clock_b_inv = chan_wave_n[2];
  assign o_last_horiz_clock = chan_wave[3];
  assign o_reference_sample_clock = chan_wave[4];
  assign o_data_sample_clock = chan_wave[5];
  assign o_inverted_clock_out = inv_clk_ff;
  assign o_drive = drv_ff;
  assign o_drive_oe_n = oe_n_ff;
  assign o_pixel_count = pix_ff;
  assign o_line_count = line_ff;
  assign o_horizontal_sync_n = hd_out_ff;
  assign o_vertical_sync_n = vd_out_ff;
  assign o_horizontal_sync_oe_n = !master_ff;
  assign o_vertical_sync_oe_n = !master_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_master_sync;
    master_ff && ext_fall;
  endsequence
  sequence s_counters_cleared;
    (pix_ff == 13'h0000) && (line_ff == 12'h000) ##0 !o_horizontal_sync_n && !o_vertical_sync_n;
  endsequence

  property p_restart;
    s_master_sync |=> s_counters_cleared;
  endproperty
  a_restart: assert property (p_restart) else $error("sync did not restart counters");

  property p_wrap;
    (pix_tick && pix_ff != hlen_ff && !restart && master_ff) |=> (phase_ff == 6'h00) && (pix_ff == $past(pix_ff) + 13'h0001);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pixel step after 48 edges wrong");

  property p_div;
    (div_ff && $changed(phase_ff)) |=> $stable(phase_ff);
  endproperty
  a_div: assert property (p_div) else $error("divided grid advanced twice");

  property p_inv_clk;
    $rose(pins_s2_ff.mclk) |=> !o_inverted_clock_out;
  endproperty
  a_inv_clk: assert property (p_inv_clk) else $error("inverted clock not complement");

  property p_slave_hd;
    (!master_ff && hd_fall) |=> (pix_ff == 13'h0000) ##1 o_horizontal_sync_oe_n;
  endproperty
  a_slave_hd: assert property (p_slave_hd) else $error("slave line start missed");

  property p_hiz;
    (drv_ff.rg == 3'h0) |=> o_drive_oe_n[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("zero drive not high impedance");

  property p_line_wrap;
    (pix_tick && pix_ff == hlen_ff && line_ff == vlen_ff && master_ff && !ext_fall) |=> (line_ff == 12'h000);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("field did not wrap");

endmodule : cht_timing

// File: test_cht_timing.sv
/*
 * Self-checking bench for the high speed clock timing block.
 * Assumes the design files, the package and cht_defs.svh are compiled first.
 */
`timescale 1ns/1ps
`include "cht_defs.svh"

module test_cht_timing;
  import cht_pkg::*;
  logic clk = 0, rst_n = 0, mclk = 0, ext_n = 1, vd_drv = 1, hd_drv = 1;
  cht_ser_t ser = 3'b100;
  logic inverted_clock_out, vs, vs_oe_n, hs, hs_oe_n, rg, a, a_n, b, b_n, hl, rsc, dsc;
  cht_drive_t drv;
  logic [5:0] drv_oe_n;
  logic [12:0] pix, mp;
  logic [11:0] line, ml;
  wire vd_w = vs_oe_n ? vd_drv : vs;
  wire hd_w = hs_oe_n ? hd_drv : hs;
  wire [5:0] w = {dsc, rsc, hl, b, a, rg};
  wire [15:0] shifts;
  wire overlap;
  int fails = 0, n_checks = 0, per = 48;

  initial begin
    forever #5 clk = ~clk;
  end

  cht_timing i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_master_clock_in(mclk), .o_inverted_clock_out(inverted_clock_out),
    .i_ser(ser), .i_ext_sync_n(ext_n), .i_vertical_sync_n(vd_w), .o_vertical_sync_n(vs),
    .o_vertical_sync_oe_n(vs_oe_n), .i_horizontal_sync_n(hd_w), .o_horizontal_sync_n(hs),
    .o_horizontal_sync_oe_n(hs_oe_n), .o_reset_gate_clock(rg), .o_horiz_clock_a(a), .o_horiz_clock_a_inv(a_n),
    .o_horiz_clock_b(b), .o_horiz_clock_b_inv(b_n), .o_last_horiz_clock(hl), .o_reference_sample_clock(rsc),
    .o_data_sample_clock(dsc), .o_drive(drv), .o_drive_oe_n(drv_oe_n), .o_pixel_count(pix), .o_line_count(line));

  cht_ccd_model i_ccd (.i_clk(clk), .i_reset_n(rst_n), .i_horiz_a(a), .i_horiz_a_inv(a_n),
    .i_drive_oe_n(drv_oe_n), .o_shift_count(shifts), .o_overlap(overlap));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Serial write and waveform measurement
  // ----------------------------------------
  task wr(input logic [7:0] ad, input logic [23:0] d);
    logic [31:0] f;
    f = {d, ad};
    @(negedge clk);
    ser.load_n = 1'b0;
    for (int i = 0; i < 32; i++) begin
      ser.sdata = f[i];
      repeat (4) @(negedge clk);
      ser.sck = 1'b1;
      repeat (4) @(negedge clk);
      ser.sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    ser.load_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : wr

  // High cycles of one output over one pixel period
  task hi(input int k, input int e);
    int c;
    c = 0;
    repeat (2 * per) @(negedge clk);
    for (int i = 0; i < per; i++) begin
      @(negedge clk);
      if (w[k] === 1'b1) c++;
      chk(a_n === ~a && b_n === ~b, "inverse pair mismatch");
    end
    chk(c == e, $sformatf("output %0d high for %0d cycles", k, c));
  endtask : hi

  task go(input logic [12:0] p, input logic [11:0] l);
    for (int i = 0; i < 1000; i++) begin
      @(negedge clk);
      if (pix === p && line === l) return;
    end
    fails++;
    $display("[FAIL] %0t %s", $time, "counter wait timed out");
    results();
  endtask : go

  // Pulse 0 external sync, 1 horizontal, 2 vertical; then look for the restart
  task sync(input int s);
    logic got;
    got = 1'b0;
    if (s == 0) ext_n = 1'b0;
    if (s == 1) hd_drv = 1'b0;
    if (s == 2) vd_drv = 1'b0;
    repeat (4) @(negedge clk);
    ext_n = 1'b1;
    hd_drv = 1'b1;
    vd_drv = 1'b1;
    for (int i = 0; i < 12 && !got; i++) begin
      @(negedge clk);
      got = pix === 13'h0000 && (s == 1 || line === 12'h000) && (s != 0 || (hs === 1'b0 && vs === 1'b0));
    end
    chk(got, $sformatf("sync %0d did not restart counters", s));
  endtask : sync

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    chk(inverted_clock_out === 1'b0 && a_n === 1'b1 && pix === 13'h0000, "state during reset");
    rst_n = 1'b1;
    @(negedge clk);
    chk(drv === `CHT_DRV_RST && drv_oe_n === 6'h00, "drive reset value");
    hi(1, 24);
    hi(0, 12);
    hi(4, 1);
    hi(5, 1);
    wr(`CHT_ADDR_HA, 24'h000AD0);
    hi(1, 23);
    wr(`CHT_ADDR_HA, 24'h001AD0);
    hi(1, 25);
    wr(`CHT_ADDR_HA, 24'h00080F);
    hi(1, 13);
    wr(`CHT_ADDR_RG, 24'h001C05);
    hi(0, 17);
    wr(`CHT_ADDR_HL, 24'h000EE0);
    hi(3, 23);
    wr(`CHT_ADDR_HB, 24'h00080F);
    hi(2, 13);
    wr(`CHT_ADDR_SMP, 24'h00017B);
    hi(4, 1);
    hi(5, 1);
    wr(`CHT_ADDR_DRV, 24'h003478);
    chk(drv === 18'h03478 && drv_oe_n === 6'h21, "drive fields");
    mclk = 1'b1;
    repeat (5) @(negedge clk);
    chk(inverted_clock_out === 1'b0, "inverted clock high input");
    mclk = 1'b0;
    repeat (5) @(negedge clk);
    chk(inverted_clock_out === 1'b1, "inverted clock low input");
    wr(`CHT_ADDR_HLEN, 24'h000003);
    wr(`CHT_ADDR_VLEN, 24'h000002);
    // Counter is already past the new line end; restart it
    sync(0);
    mp = 13'h0000;
    ml = 12'h000;
    repeat (1200) begin
      @(negedge clk);
      if (pix > mp) mp = pix;
      if (line > ml) ml = line;
    end
    chk(mp === 13'h0003 && ml === 12'h002, "counter wrap points");
    go(13'h0002, 12'h001);
    sync(0);
    wr(`CHT_ADDR_MODE, 24'h000000);
    chk(vs_oe_n === 1'b1 && hs_oe_n === 1'b1, "sync pins released in slave mode");
    go(13'h0002, 12'h001);
    sync(1);
    go(13'h0002, 12'h001);
    sync(2);
    hi(1, 13);
    wr(`CHT_ADDR_DIV, 24'h000001);
    per = 96;
    hi(1, 26);
    hi(4, 2);
    chk(overlap === 1'b0 && shifts !== 16'h0000, "sensor saw bad horizontal clocks");
    results();
  end
endmodule : test_cht_timing
